//--- logic/afpg_alert_out.sv
// Latched or transparent alert output with flag-read release.
// Assumes condition is a level from the comparison logic.
`timescale 1ns/1ps
module afpg_alert_out
	import afpg_pkg::*;
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic cond,
	input  wire logic latch_en,
	input  wire logic release_rd,
	output logic      alert
);
	typedef struct packed {
		logic hold;
	} afpg_ao_s;
	afpg_ao_s st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		// New condition beats the release in the same cycle
		if (cond && latch_en)
			st_nxt.hold = 1'b1; // R20
		else if (release_rd || !latch_en)
			st_nxt.hold = 1'b0; // R20
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign alert = cond | st_r.hold; // R5 R6
endmodule : afpg_alert_out

//--- logic/afpg_pkg.sv
// Package for the alert, flag and power-good register bank.
// Assumes a 16-bit register port driven by the serial-bus front end.
package afpg_pkg;
	localparam int          AFPG_NCH          = 3;
	localparam int          AFPG_DW           = 16;
	localparam logic [7:0]  AFPG_ADDR_ALERT   = 8'h0F;
	localparam logic [7:0]  AFPG_ADDR_PG_UP   = 8'h10;
	localparam logic [7:0]  AFPG_ADDR_PG_LO   = 8'h11;
	localparam logic [7:0]  AFPG_ADDR_MAKER   = 8'hFE;
	localparam logic [15:0] AFPG_RST_PG_UP    = 16'h2710;
	localparam logic [15:0] AFPG_RST_PG_LO    = 16'h2328;
	// Arbitrary neutral value
	localparam logic [15:0] AFPG_MAKER_ID     = 16'hA5C3;
	localparam int          AFPG_SUM_SEL_LSB  = 12;
	localparam int          AFPG_WARN_LAT_BIT = 11;
	localparam int          AFPG_CRIT_LAT_BIT = 10;
	localparam int          AFPG_CRIT_LSB     = 7;
	localparam int          AFPG_SUM_FLAG_BIT = 6;
	localparam int          AFPG_WARN_LSB     = 3;
	localparam int          AFPG_PG_FLAG_BIT  = 2;
	localparam int          AFPG_TC_FLAG_BIT  = 1;
	localparam int          AFPG_RDY_FLAG_BIT = 0;
	localparam int          AFPG_LIM_MSB      = 15;
	localparam int          AFPG_LIM_LSB      = 3;
	localparam logic [15:0] AFPG_LIM_MASK     = 16'hFFF8;
	localparam logic [15:0] AFPG_ZERO16       = 16'h0000;
	typedef enum logic [0:0] {
		AFPG_PG_LOW  = 1'b0,
		AFPG_PG_HIGH = 1'b1
	} afpg_pg_e;
endpackage : afpg_pkg

//--- logic/afpg_power_good.sv
// Power-good hysteresis comparator over all bus channels.
// Assumes bus readings use the same signed format as the limits.
`timescale 1ns/1ps
module afpg_power_good
	import afpg_pkg::*;
#(
	parameter int NCH = AFPG_NCH
) (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic [NCH*16-1:0]    bus_volt,
	input  wire logic                 bus_valid,
	input  wire logic                 bus_meas_on,
	input  wire logic [15:0]          upper_lim,
	input  wire logic [15:0]          lower_lim,
	output logic                      pg
);
	typedef struct packed {
		afpg_pg_e state;
	} afpg_pg_s;
	afpg_pg_s st_r, st_nxt;
	logic [NCH-1:0] above, below;

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_cmp
			logic signed [AFPG_LIM_MSB-AFPG_LIM_LSB:0] v;
			assign v = bus_volt[g*AFPG_DW+AFPG_LIM_MSB -: AFPG_LIM_MSB-AFPG_LIM_LSB+1];
			assign above[g] = v > $signed(upper_lim[AFPG_LIM_MSB:AFPG_LIM_LSB]);
			assign below[g] = v < $signed(lower_lim[AFPG_LIM_MSB:AFPG_LIM_LSB]);
		end
	endgenerate

	always_comb begin
		st_nxt = st_r;
		if (bus_valid && bus_meas_on) begin
			case (st_r.state)
				AFPG_PG_LOW:  if (&above) st_nxt.state = AFPG_PG_HIGH; // R13
				AFPG_PG_HIGH: if (|below) st_nxt.state = AFPG_PG_LOW; // R14
				default:      st_nxt.state = AFPG_PG_LOW;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			st_r <= '{state: AFPG_PG_LOW};
		else
			st_r <= st_nxt;
	end

	assign pg = (st_r.state == AFPG_PG_HIGH);
endmodule : afpg_power_good

//--- logic/afpg_regs.sv
// Alert control, flag, power-good limit and identification registers.
// Assumes a 16-bit register port from the serial front end: one-cycle
// read and write strobes with an 8-bit register pointer. Event inputs are
// one-cycle pulses from the conversion engine.
//
// Overview of operation
// R1: Reading the alert control register clears critical, sum, warning and ready flags.
// R2: Writing the alert control register changes control fields only, never flags.
// R3: Host should read flags clear before changing warning settings.
// R4: Bits 14-12 pick channels for the shunt sum only.
// R5: Bit 11 makes the warning output latched when set, else transparent.
// R6: Bit 10 makes the critical output latched when set, else transparent.
// R7: Bits 9-7 set on per-channel critical exceed; critical output asserts.
// R8: Bit 6 sets when sum exceeds sum limit; critical output asserts.
// R9: Bits 5-3 set on averaged warning exceed; warning output asserts.
// R10: Bit 2 mirrors power-good output and is not cleared by reads.
// R11: Bit 1 mirrors timing output, resets to one, sticky until reset.
// R12: Bit 0 sets on conversions done; clears on config write or read.
// R13: Power-good goes high once every bus channel exceeds the upper limit.
// R14: Power-good drops as soon as any channel falls below the lower limit.
// R15: Host must enable bus measurements for power-good monitoring.
// R16: Limit registers hold sign and 12-bit value in 15-3; 2-0 reserved.
// R17: Upper limit resets to 2710h, lower limit to 2328h.
// R18: A read-only identification register returns a fixed value.
// R19: Sum compare uses the sum refreshed after each full channel cycle.
// R20: Latched outputs hold until the alert register is read.
`timescale 1ns/1ps
module afpg_regs
	import afpg_pkg::*;
#(
	parameter int NCH = AFPG_NCH
) (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic [7:0]           reg_addr,
	input  wire logic                 reg_wr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_rd,
	output logic [15:0]               reg_rdata,
	input  wire logic [NCH-1:0]       crit_exceed,
	input  wire logic [NCH-1:0]       warn_exceed,
	input  wire logic                 sum_done,
	input  wire logic [15:0]          sum_value,
	input  wire logic [15:0]          sum_limit,
	input  wire logic                 conv_done,
	input  wire logic                 cfg_wr_active,
	input  wire logic [NCH*16-1:0]    bus_volt,
	input  wire logic                 bus_valid,
	input  wire logic                 bus_meas_on,
	input  wire logic                 timing_control_output,
	output logic [NCH-1:0]            sum_channel_select,
	output logic                      critical_alert,
	output logic                      warning_alert,
	output logic                      power_good_output
);
	typedef struct packed {
		logic [NCH-1:0] sum_sel;
		logic           warn_lat;
		logic           crit_lat;
		logic [NCH-1:0] crit_flags;
		logic           sum_flag;
		logic [NCH-1:0] warn_flags;
		logic           tc_flag;
		logic           rdy_flag;
		logic           sum_over;
		logic [15:0]    pg_upper;
		logic [15:0]    pg_lower;
		logic [15:0]    rdata;
	} afpg_regs_s;

	localparam afpg_regs_s AFPG_REGS_RST = '{
		sum_sel:    '0,
		warn_lat:   1'b0,
		crit_lat:   1'b0,
		crit_flags: '0,
		sum_flag:   1'b0,
		warn_flags: '0,
		tc_flag:    1'b1,
		rdy_flag:   1'b0,
		sum_over:   1'b0,
		pg_upper:   AFPG_RST_PG_UP,
		pg_lower:   AFPG_RST_PG_LO,
		rdata:      AFPG_ZERO16
	};

	afpg_regs_s st_r, st_nxt;
	logic       rd_alert;
	logic       wr_alert;
	logic       crit_cond;
	logic       warn_cond;
	logic       sum_exceed;
	logic       pg_level;
	logic [15:0] alert_word;

	assign rd_alert   = reg_rd && (reg_addr == AFPG_ADDR_ALERT);
	assign wr_alert   = reg_wr && (reg_addr == AFPG_ADDR_ALERT);
	assign sum_exceed = $signed(sum_value) > $signed(sum_limit);

	always_comb begin
		alert_word = AFPG_ZERO16;
		alert_word[AFPG_SUM_SEL_LSB +: NCH] = st_r.sum_sel;
		alert_word[AFPG_WARN_LAT_BIT]       = st_r.warn_lat;
		alert_word[AFPG_CRIT_LAT_BIT]       = st_r.crit_lat;
		alert_word[AFPG_CRIT_LSB +: NCH]    = st_r.crit_flags;
		alert_word[AFPG_SUM_FLAG_BIT]       = st_r.sum_flag;
		alert_word[AFPG_WARN_LSB +: NCH]    = st_r.warn_flags;
		alert_word[AFPG_PG_FLAG_BIT]        = pg_level; // R10
		alert_word[AFPG_TC_FLAG_BIT]        = st_r.tc_flag;
		alert_word[AFPG_RDY_FLAG_BIT]       = st_r.rdy_flag;
	end

	always_comb begin
		st_nxt = st_r;
		// Control fields only; flag bits of the write data are dropped
		if (wr_alert) begin
			st_nxt.sum_sel  = reg_wdata[AFPG_SUM_SEL_LSB +: NCH]; // R2 R4
			st_nxt.warn_lat = reg_wdata[AFPG_WARN_LAT_BIT]; // R2 R5
			st_nxt.crit_lat = reg_wdata[AFPG_CRIT_LAT_BIT]; // R2 R6
		end
		if (reg_wr && reg_addr == AFPG_ADDR_PG_UP)
			st_nxt.pg_upper = reg_wdata & AFPG_LIM_MASK; // R16
		if (reg_wr && reg_addr == AFPG_ADDR_PG_LO)
			st_nxt.pg_lower = reg_wdata & AFPG_LIM_MASK; // R16
		// Sum compare result held between complete channel cycles
		if (sum_done)
			st_nxt.sum_over = sum_exceed; // R19
		// Clear first, set afterwards: an event in the read cycle survives
		if (rd_alert) begin
			st_nxt.crit_flags = '0; // R1
			st_nxt.sum_flag   = 1'b0; // R1
			st_nxt.warn_flags = '0; // R1
			st_nxt.rdy_flag   = 1'b0; // R1
		end
		if (cfg_wr_active)
			st_nxt.rdy_flag = 1'b0; // R12
		st_nxt.crit_flags = st_nxt.crit_flags | crit_exceed; // R7
		st_nxt.warn_flags = st_nxt.warn_flags | warn_exceed; // R9
		if (sum_done && sum_exceed)
			st_nxt.sum_flag = 1'b1; // R8
		if (conv_done)
			st_nxt.rdy_flag = 1'b1; // R12
		// Sticky: nothing lowers it; reset also loads one
		if (timing_control_output)
			st_nxt.tc_flag = 1'b1; // R11
		if (reg_rd) begin
			case (reg_addr)
				AFPG_ADDR_ALERT: st_nxt.rdata = alert_word;
				AFPG_ADDR_PG_UP: st_nxt.rdata = st_r.pg_upper;
				AFPG_ADDR_PG_LO: st_nxt.rdata = st_r.pg_lower;
				AFPG_ADDR_MAKER: st_nxt.rdata = AFPG_MAKER_ID; // R18
				default:         st_nxt.rdata = AFPG_ZERO16;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			st_r <= AFPG_REGS_RST; // R17
		else
			st_r <= st_nxt;
	end

	// Live conditions for transparent mode; the sum term follows the held compare
	assign crit_cond = (|crit_exceed) | st_r.sum_over; // R7 R8
	assign warn_cond = |warn_exceed; // R9

	afpg_alert_out u_crit (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.cond       (crit_cond),
		.latch_en   (st_r.crit_lat),
		.release_rd (rd_alert),
		.alert      (critical_alert)
	);

	afpg_alert_out u_warn (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.cond       (warn_cond),
		.latch_en   (st_r.warn_lat),
		.release_rd (rd_alert),
		.alert      (warning_alert)
	);

	// Monitoring relies on the host enabling bus conversions
	afpg_power_good #(.NCH(NCH)) u_pg (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.bus_volt    (bus_volt),
		.bus_valid   (bus_valid),
		.bus_meas_on (bus_meas_on), // R15
		.upper_lim   (st_r.pg_upper),
		.lower_lim   (st_r.pg_lower),
		.pg          (pg_level)
	);

	assign power_good_output  = pg_level; // R13 R14
	assign sum_channel_select = st_r.sum_sel; // R4
	assign reg_rdata          = st_r.rdata;
endmodule : afpg_regs

//--- tb/afpg_host_model.sv
// Host-side register master speaking the one-cycle strobe protocol.
// Assumes read data is registered and settles on the read edge.
`timescale 1ns/1ps
module afpg_host_model (
	input  wire logic        clk,
	input  wire logic [15:0] reg_rdata,
	output logic [7:0]       reg_addr,
	output logic             reg_wr,
	output logic [15:0]      reg_wdata,
	output logic             reg_rd
);
	initial begin
		reg_addr  = 8'h00;
		reg_wr    = 1'b0;
		reg_wdata = 16'h0000;
		reg_rd    = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		// Stale data is inverted so a late sample cannot pass by luck
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] q);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		q = reg_rdata;
	endtask : rd
endmodule : afpg_host_model

//--- tb/afpg_regs_monitor.sv
// Checker for the alert, flag and power-good register bank.
// Assumes it is bound into afpg_regs and sees only its ports.
`timescale 1ns/1ps
module afpg_regs_monitor
	import afpg_pkg::*;
#(
	parameter int NCH = AFPG_NCH
) (
	input wire logic           clk,
	input wire logic           sys_rst,
	input wire logic [7:0]     reg_addr,
	input wire logic           reg_wr,
	input wire logic [15:0]    reg_wdata,
	input wire logic           reg_rd,
	input wire logic [15:0]    reg_rdata,
	input wire logic [NCH-1:0] crit_exceed,
	input wire logic [NCH-1:0] warn_exceed,
	input wire logic           bus_valid,
	input wire logic           bus_meas_on,
	input wire logic [NCH-1:0] sum_channel_select,
	input wire logic           critical_alert,
	input wire logic           warning_alert,
	input wire logic           power_good_output
);
	logic wen_r;
	wire  rd_a = reg_rd && reg_addr == AFPG_ADDR_ALERT;
	wire  wr_a = reg_wr && reg_addr == AFPG_ADDR_ALERT;
	// Mirror of the warning latch mode, so hold checks skip transparent spells
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) wen_r <= 1'b0;
		else if (wr_a) wen_r <= reg_wdata[11];
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_crit_out_now: assert property (|crit_exceed |-> critical_alert)
		else $error("critical alert missing");
	a_warn_out_now: assert property (|warn_exceed |-> warning_alert)
		else $error("warning alert missing");
	a_sel_follows_wr: assert property (wr_a |=> sum_channel_select == $past(reg_wdata[14:12]))
		else $error("sum select not loaded");
	a_warn_latch_hold: assert property (wen_r && warning_alert && !rd_a && !wr_a |=> warning_alert)
		else $error("latched warning dropped");
	a_pg_on_sample: assert property ($changed(power_good_output) |-> $past(bus_valid) && $past(bus_meas_on))
		else $error("power good moved without sample");
	a_tc_flag_sticky: assert property (rd_a |=> reg_rdata[1])
		else $error("timing flag lost");
	a_pg_flag_copy: assert property (rd_a |=> reg_rdata[2] == $past(power_good_output))
		else $error("power good flag mismatch");
	a_maker_fixed: assert property (reg_rd && reg_addr == AFPG_ADDR_MAKER |=> reg_rdata == AFPG_MAKER_ID)
		else $error("identification changed");
	a_lim_low_zero: assert property (reg_rd && reg_addr inside {8'h10, 8'h11} |=> reg_rdata[2:0] == 3'h0)
		else $error("limit reserved bits set");
	c_alert_read: cover property (rd_a);
	c_pg_rise: cover property ($rose(power_good_output));
	c_warn_held: cover property (wen_r && warning_alert && !(|warn_exceed));
endmodule : afpg_regs_monitor
bind afpg_regs afpg_regs_monitor #(.NCH(NCH)) u_mon (.clk(clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .crit_exceed(crit_exceed), .warn_exceed(warn_exceed),
	.bus_valid(bus_valid), .bus_meas_on(bus_meas_on), .sum_channel_select(sum_channel_select),
	.critical_alert(critical_alert), .warning_alert(warning_alert),
	.power_good_output(power_good_output));

//--- tb/afpg_regs_tb.sv
// Self-checking bench for the alert, flag and power-good register bank.
// Assumes the host model drives the register strobes.
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_count++; \
	$display("wrong value %s expected %h seen %h", n, e, a); end end
module afpg_regs_tb
	import afpg_pkg::*;
;
	logic        clk, sys_rst, reg_wr, reg_rd, sum_done, conv_done, cfg_wr_active;
	logic        bus_valid, bus_meas_on, tco, crit_a, warn_a, pg;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, sum_value, sum_limit;
	logic [2:0]  crit_exceed, warn_exceed, sel;
	logic [47:0] bus_volt;
	logic [9:0]  ev;
	int          err_count, check_count, cyc;
	assign {crit_exceed, warn_exceed, sum_done, conv_done, cfg_wr_active, bus_valid} = ev;
	afpg_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
	afpg_regs #(.NCH(3)) uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.crit_exceed(crit_exceed), .warn_exceed(warn_exceed), .sum_done(sum_done),
		.sum_value(sum_value), .sum_limit(sum_limit), .conv_done(conv_done),
		.cfg_wr_active(cfg_wr_active), .bus_volt(bus_volt), .bus_valid(bus_valid),
		.bus_meas_on(bus_meas_on), .timing_control_output(tco), .sum_channel_select(sel),
		.critical_alert(crit_a), .warning_alert(warn_a), .power_good_output(pg));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish
	task automatic pulse(input logic [9:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 10'h000;
		#1;
	endtask : pulse
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] q;
		host.rd(a, q);
		`CHK("read data", e, q)
	endtask : rchk
	initial begin
		clk = 0; sys_rst = 1; ev = 0; tco = 0; bus_meas_on = 0;
		sum_value = 16'h0100; sum_limit = 16'h0080; bus_volt = {3{16'h2800}};
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rchk(8'h0F, 16'h0002);
		rchk(8'h10, 16'h2710);
		rchk(8'h11, 16'h2328);
		host.wr(8'hFE, 16'h0000);
		rchk(8'hFE, AFPG_MAKER_ID);
		rchk(8'h20, 16'h0000);
		host.wr(8'h10, 16'h1234);
		rchk(8'h10, 16'h1230);
		host.wr(8'h11, 16'h232F);
		rchk(8'h11, 16'h2328);
		host.wr(8'h0F, 16'hFFFF);
		rchk(8'h0F, 16'h7C02);
		`CHK("sum select", 3'h7, sel)
		pulse(10'b111_000_0000);
		`CHK("critical held", 1'b1, crit_a)
		rchk(8'h0F, 16'h7F82);
		`CHK("critical released", 1'b0, crit_a)
		pulse(10'b000_111_1100);
		`CHK("warning held", 1'b1, warn_a)
		rchk(8'h0F, 16'h7C7B);
		@(posedge clk) sum_value <= 16'h0010;
		pulse(10'b000_000_1000);
		rchk(8'h0F, 16'h7C02);
		`CHK("critical idle", 1'b0, crit_a)
		host.wr(8'h0F, 16'h0000);
		@(posedge clk) ev <= 10'b000_111_0000;
		#1;
		`CHK("warning live", 1'b1, warn_a)
		pulse(10'h004);
		`CHK("warning follows", 1'b0, warn_a)
		pulse(10'h002);
		rchk(8'h0F, 16'h003A);
		// Restore the upper limit so the 2400h step sits inside the hysteresis band
		host.wr(8'h10, 16'h2710);
		@(posedge clk) bus_meas_on <= 1'b1;
		pulse(10'h001);
		`CHK("power good", 1'b1, pg)
		rchk(8'h0F, 16'h0006);
		@(posedge clk) bus_volt <= {3{16'h2400}};
		pulse(10'h001);
		`CHK("power good", 1'b1, pg)
		rchk(8'h0F, 16'h0006);
		@(posedge clk) bus_volt <= {16'h2800, 16'h2300, 16'h2800};
		pulse(10'h001);
		`CHK("power good", 1'b0, pg)
		tally_and_finish();
	end
endmodule : afpg_regs_tb
